// [timer16_pkg.sv]
// timer16_pkg: shared constants for the 16-bit timer counter/capture block
// assumes: an 8-bit processor bus with one-cycle read and write strobes
package timer16_pkg;

  // ---------------------------------------------------------------
  // register locations on the 8-bit bus
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL_A   = 4'h0;
  localparam logic [3:0] ADDR_CTRL_B   = 4'h1;
  localparam logic [3:0] ADDR_CNT_LO   = 4'h2;
  localparam logic [3:0] ADDR_CNT_HI   = 4'h3;
  localparam logic [3:0] ADDR_CAP_LO   = 4'h4;
  localparam logic [3:0] ADDR_CAP_HI   = 4'h5;
  localparam logic [3:0] ADDR_CMPA_LO  = 4'h6;
  localparam logic [3:0] ADDR_CMPA_HI  = 4'h7;
  localparam logic [3:0] ADDR_FLAGS    = 4'h8;
  localparam logic [3:0] ADDR_MASK     = 4'h9;
  localparam logic [3:0] ADDR_CMP_CTRL = 4'hA;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int POS_FILTER_EN = 7;  // timer_control_b
  localparam int POS_EDGE_SEL  = 6;  // timer_control_b, 1 = rising
  localparam int POS_WGM_HI    = 3;  // timer_control_b bits 4:3
  localparam int POS_CS        = 0;  // timer_control_b bits 2:0
  localparam int POS_WGM_LO    = 0;  // timer_control_a bits 1:0
  localparam int POS_CAP_FLAG  = 5;  // flags / mask
  localparam int POS_OVF_FLAG  = 2;  // flags / mask
  localparam int POS_CMP_SEL   = 2;  // comparator_control_register

  // ---------------------------------------------------------------
  // reset values and counts
  // ---------------------------------------------------------------
  localparam logic [7:0]  RESET_BYTE   = 8'h00;
  localparam logic [15:0] RESET_WORD   = 16'h0000;
  localparam logic [15:0] CEIL_8BIT    = 16'h00FF;
  localparam logic [15:0] CEIL_9BIT    = 16'h01FF;
  localparam logic [15:0] CEIL_10BIT   = 16'h03FF;
  localparam logic [15:0] COUNT_MAX    = 16'hFFFF;
  localparam int          FILTER_TAPS  = 4;
  localparam logic [9:0]  DIV_8        = 10'h007;
  localparam logic [9:0]  DIV_64       = 10'h03F;
  localparam logic [9:0]  DIV_256      = 10'h0FF;
  localparam logic [9:0]  DIV_1024     = 10'h3FF;

  // host side operations
  typedef enum logic [1:0] {OP_WRITE16, OP_READ16, OP_WRITE8, OP_READ8}
    host_op_t;

endpackage : timer16_pkg

// [timer16_bus_if.sv]
// timer16_bus_if: 8-bit register bus between processor end and timer end
// assumes: both ends share MCLK; strobes last one cycle
`timescale 1ns/1ns
interface timer16_bus_if;
  logic [3:0] addr;
  logic       wr;
  logic       rd;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       capture_irq;
  logic       overflow_irq;
  logic       capture_ack;
  logic       overflow_ack;

  modport device (input addr, wr, rd, wdata, capture_ack, overflow_ack,
                  output rdata, capture_irq, overflow_irq);
  modport host   (output addr, wr, rd, wdata, capture_ack, overflow_ack,
                  input rdata, capture_irq, overflow_irq);
endinterface : timer16_bus_if

// [timer16_device.sv]
// timer16_device: counter unit and input capture unit of a 16-bit timer
// assumes: processor end drives the bus on MCLK; pins are asynchronous
`timescale 1ns/1ns
module timer16_device
  import timer16_pkg::*;
(
  // clock and reset
  input  wire logic MCLK,
  input  wire logic RST,
  // register bus
  timer16_bus_if.device BUS,
  // capture sources, asynchronous
  input  wire logic CAPTURE_PIN,
  input  wire logic COMPARATOR_OUT,
  // counter indications
  output logic      CEILING,
  output logic      FLOOR
);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0]  timer_control_a;
  logic [7:0]  timer_control_b;
  logic [7:0]  comparator_control_register;
  logic [7:0]  mask;
  logic [7:0]  holding;
  logic [15:0] count_value;
  logic [15:0] capture_register;
  logic [15:0] compare_a_register;
  logic        capture_flag;
  logic        counter_overflow_flag;
  logic        count_down;
  logic [9:0]  prescale;
  logic        timer_tick;
  logic [3:0]  waveform_generation_mode;
  logic [2:0]  clock_selection_field;
  logic [15:0] ceiling;
  logic        dual_slope;
  logic        fast_mode;
  logic        capture_ceiling_mode;

  // bus decodes
  logic wr_cnt_lo;
  logic rd_cnt_lo;
  logic wr_cap_lo;
  logic rd_cap_lo;
  logic wr_flags;

  assign waveform_generation_mode = {timer_control_b[POS_WGM_HI +: 2],
                                     timer_control_a[POS_WGM_LO +: 2]};
  assign clock_selection_field    = timer_control_b[POS_CS +: 3];
  assign wr_cnt_lo = BUS.wr && BUS.addr == ADDR_CNT_LO;
  assign rd_cnt_lo = BUS.rd && BUS.addr == ADDR_CNT_LO;
  assign wr_cap_lo = BUS.wr && BUS.addr == ADDR_CAP_LO;
  assign rd_cap_lo = BUS.rd && BUS.addr == ADDR_CAP_LO;
  assign wr_flags  = BUS.wr && BUS.addr == ADDR_FLAGS;

  // ---------------------------------------------------------------
  // mode decode
  // ---------------------------------------------------------------
  // ceiling per waveform mode; reserved mode 13 counts as normal
  always_comb
  begin
    case (waveform_generation_mode)
      4'h1, 4'h5: ceiling = CEIL_8BIT;
      4'h2, 4'h6: ceiling = CEIL_9BIT;
      4'h3, 4'h7: ceiling = CEIL_10BIT;
      4'h4, 4'h9, 4'hB, 4'hF: ceiling = compare_a_register;
      4'h8, 4'hA, 4'hC, 4'hE: ceiling = capture_register;
      default: ceiling = COUNT_MAX;
    endcase
  end

  assign dual_slope = waveform_generation_mode inside
                      {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB};
  assign fast_mode  = waveform_generation_mode inside
                      {4'h5, 4'h6, 4'h7, 4'hE, 4'hF};
  assign capture_ceiling_mode = waveform_generation_mode inside
                                {4'h8, 4'hA, 4'hC, 4'hE};

  // ---------------------------------------------------------------
  // timer tick from prescaler
  // ---------------------------------------------------------------
  // free-running divider; selections 6 and 7 are left as stopped here
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
      prescale <= 10'h000;
    else
      prescale <= prescale + 10'h001;
  end

  always_comb
  begin
    case (clock_selection_field)
      3'h1:    timer_tick = 1'b1;
      3'h2:    timer_tick = (prescale[2:0] == DIV_8[2:0]);
      3'h3:    timer_tick = (prescale[5:0] == DIV_64[5:0]);
      3'h4:    timer_tick = (prescale[7:0] == DIV_256[7:0]);
      3'h5:    timer_tick = (prescale == DIV_1024);
      default: timer_tick = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // counter unit
  // ---------------------------------------------------------------
  assign CEILING = (count_value == ceiling);
  assign FLOOR   = (count_value == RESET_WORD);

  // a processor low-byte write wins over any tick in the same cycle
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      count_value <= RESET_WORD;
      count_down  <= 1'b0;
    end
    else if (wr_cnt_lo)
      count_value <= {holding, BUS.wdata};
    else if (timer_tick)
    begin
      if (dual_slope)
      begin
        if (CEILING)
        begin
          count_down  <= 1'b1;
          count_value <= count_value - 16'h0001;
        end
        else if (FLOOR)
        begin
          count_down  <= 1'b0;
          count_value <= count_value + 16'h0001;
        end
        else if (count_down)
          count_value <= count_value - 16'h0001;
        else
          count_value <= count_value + 16'h0001;
      end
      else if (CEILING)
        count_value <= RESET_WORD;
      else
        count_value <= count_value + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // capture source, synchroniser and filter
  // ---------------------------------------------------------------
  logic [1:0] pin_sync;
  logic [1:0] cmp_sync;
  logic       source;
  logic [FILTER_TAPS-2:0] samples;
  logic       filtered;
  logic       detect_in;
  logic       detect_prev;
  logic       capture_event;

  // first stage feeds only the second stage
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      pin_sync <= 2'b00;
      cmp_sync <= 2'b00;
    end
    else
    begin
      pin_sync <= {pin_sync[0], CAPTURE_PIN};
      cmp_sync <= {cmp_sync[0], COMPARATOR_OUT};
    end
  end

  // switching source may itself look like an edge
  assign source = comparator_control_register[POS_CMP_SEL] ?
                  cmp_sync[1] : pin_sync[1];

  // filter runs on MCLK regardless of the prescaler
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      samples  <= '0;
      filtered <= 1'b0;
    end
    else
    begin
      // the live sample is the fourth; a full extra stage adds a cycle
      samples <= {samples[FILTER_TAPS-3:0], source};
      if ({samples, source} == '1)
        filtered <= 1'b1;
      else if ({samples, source} == '0)
        filtered <= 1'b0;
    end
  end

  assign detect_in = timer_control_b[POS_FILTER_EN] ?
                     filtered : source;

  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
      detect_prev <= 1'b0;
    else
      detect_prev <= detect_in;
  end

  // edge detector is idle while capture defines the ceiling
  assign capture_event = !capture_ceiling_mode &&
                         (detect_in != detect_prev) &&
                         (detect_in == timer_control_b[POS_EDGE_SEL]);

  // ---------------------------------------------------------------
  // capture register
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
      capture_register <= RESET_WORD;
    else if (capture_event)
      capture_register <= count_value;
    else if (wr_cap_lo && capture_ceiling_mode)
      capture_register <= {holding, BUS.wdata};
  end

  // ---------------------------------------------------------------
  // flags: hardware set wins over clear
  // ---------------------------------------------------------------
  logic overflow_event;
  assign overflow_event = timer_tick && !wr_cnt_lo &&
    (dual_slope ? (FLOOR && count_down) :
     fast_mode  ? CEILING : (count_value == COUNT_MAX));

  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      capture_flag          <= 1'b0;
      counter_overflow_flag <= 1'b0;
    end
    else
    begin
      if (capture_event)
        capture_flag <= 1'b1;
      else if (BUS.capture_ack ||
               (wr_flags && BUS.wdata[POS_CAP_FLAG]))
        capture_flag <= 1'b0;
      if (overflow_event)
        counter_overflow_flag <= 1'b1;
      else if (BUS.overflow_ack ||
               (wr_flags && BUS.wdata[POS_OVF_FLAG]))
        counter_overflow_flag <= 1'b0;
    end
  end

  assign BUS.capture_irq  = capture_flag &&
                            mask[POS_CAP_FLAG];
  assign BUS.overflow_irq = counter_overflow_flag &&
                            mask[POS_OVF_FLAG];

  // ---------------------------------------------------------------
  // control registers and holding byte
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      timer_control_a             <= RESET_BYTE;
      timer_control_b             <= RESET_BYTE;
      comparator_control_register <= RESET_BYTE;
      mask                        <= RESET_BYTE;
      compare_a_register          <= RESET_WORD;
    end
    else if (BUS.wr)
    begin
      case (BUS.addr)
        ADDR_CTRL_A:   timer_control_a             <= BUS.wdata;
        ADDR_CTRL_B:   timer_control_b             <= BUS.wdata;
        ADDR_CMP_CTRL: comparator_control_register <= BUS.wdata;
        ADDR_MASK:     mask                        <= BUS.wdata;
        ADDR_CMPA_LO:  compare_a_register <= {holding, BUS.wdata};
        default: ;
      endcase
    end
  end

  // one holding byte shared by every 16-bit register
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
      holding <= RESET_BYTE;
    else if (rd_cnt_lo)
      holding <= count_value[15:8];
    else if (rd_cap_lo)
      holding <= capture_register[15:8];
    else if (BUS.wr && BUS.addr inside
             {ADDR_CNT_HI, ADDR_CAP_HI, ADDR_CMPA_HI})
      holding <= BUS.wdata;
  end

  // ---------------------------------------------------------------
  // read data, one cycle after the read strobe
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
      BUS.rdata <= RESET_BYTE;
    else if (BUS.rd)
    begin
      case (BUS.addr)
        ADDR_CTRL_A:   BUS.rdata <= timer_control_a;
        ADDR_CTRL_B:   BUS.rdata <= timer_control_b;
        ADDR_CNT_LO:   BUS.rdata <= count_value[7:0];
        ADDR_CNT_HI:   BUS.rdata <= holding;
        ADDR_CAP_LO:   BUS.rdata <= capture_register[7:0];
        ADDR_CAP_HI:   BUS.rdata <= holding;
        ADDR_CMPA_LO:  BUS.rdata <= compare_a_register[7:0];
        ADDR_CMPA_HI:  BUS.rdata <= compare_a_register[15:8];
        ADDR_FLAGS:    BUS.rdata <= 8'(capture_flag << POS_CAP_FLAG) |
                          8'(counter_overflow_flag << POS_OVF_FLAG);
        ADDR_MASK:     BUS.rdata <= mask;
        ADDR_CMP_CTRL: BUS.rdata <= comparator_control_register;
        default:       BUS.rdata <= RESET_BYTE;
      endcase
    end
  end

endmodule : timer16_device

// [timer16_host.sv]
// timer16_host: processor-side end turning 16-bit requests into byte access
// assumes: device answers a read one cycle after the read strobe
`timescale 1ns/1ns
module timer16_host
  import timer16_pkg::*;
(
  // clock and reset
  input  wire logic        MCLK,
  input  wire logic        RST,
  // register bus
  timer16_bus_if.host      BUS,
  // user request
  input  wire logic        REQ,
  input  wire host_op_t    OP,
  input  wire logic [3:0]  ADDR,
  input  wire logic [15:0] WDATA,
  output logic             BUSY,
  output logic             DONE,
  output logic [15:0]      RDATA,
  // interrupt service
  output logic             CAPTURE_IRQ,
  output logic             OVERFLOW_IRQ,
  input  wire logic        CAPTURE_SERVICE,
  input  wire logic        OVERFLOW_SERVICE
);

  typedef enum logic [1:0] {IDLE, FIRST, SECOND, FINISH} state_t;

  state_t      state;
  host_op_t    op;
  logic [3:0]  base;
  logic [15:0] data;

  // ---------------------------------------------------------------
  // sequencer: write high then low, read low then high
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      state <= IDLE;
      op    <= OP_WRITE8;
      base  <= 4'h0;
      data  <= 16'h0000;
    end
    else
    begin
      case (state)
        IDLE:
          if (REQ)
          begin
            op    <= OP;
            base  <= ADDR;
            data  <= WDATA;
            state <= FIRST;
          end
        FIRST:
          state <= (op inside {OP_WRITE16, OP_READ16}) ? SECOND : FINISH;
        SECOND:
          state <= FINISH;
        FINISH:
          state <= IDLE;
        default:
          state <= IDLE;
      endcase
    end
  end

  // byte strobes; base names the low byte, base+1 the high byte
  always_comb
  begin
    BUS.wr    = 1'b0;
    BUS.rd    = 1'b0;
    BUS.addr  = base;
    BUS.wdata = data[7:0];
    case (state)
      FIRST:
        case (op)
          OP_WRITE16:
          begin
            BUS.wr    = 1'b1;
            BUS.addr  = base + 4'h1;
            BUS.wdata = data[15:8];
          end
          OP_WRITE8: BUS.wr = 1'b1;
          default:   BUS.rd = 1'b1;
        endcase
      SECOND:
      begin
        BUS.wr   = (op == OP_WRITE16);
        BUS.rd   = (op == OP_READ16);
        BUS.addr = (op == OP_READ16) ? base + 4'h1 : base;
      end
      default: ;
    endcase
  end

  // collect read bytes as they return
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
      RDATA <= 16'h0000;
    else if (state == SECOND && op == OP_READ16)
      RDATA[7:0] <= BUS.rdata;
    else if (state == FINISH && op == OP_READ16)
      RDATA[15:8] <= BUS.rdata;
    else if (state == FINISH && op == OP_READ8)
      RDATA <= {8'h00, BUS.rdata};
  end

  assign BUSY = (state != IDLE);
  assign DONE = (state == FINISH);

  // interrupt service clears the device flag automatically
  assign CAPTURE_IRQ      = BUS.capture_irq;
  assign OVERFLOW_IRQ     = BUS.overflow_irq;
  assign BUS.capture_ack  = CAPTURE_SERVICE && BUS.capture_irq;
  assign BUS.overflow_ack = OVERFLOW_SERVICE && BUS.overflow_irq;

endmodule : timer16_host

// [timer16_props.sv]
// timer16_props: bus-side checks of the counter and capture registers
// assumes: wired by name beside the bus interface, one MCLK domain
`timescale 1ns/1ns
module timer16_props
  import timer16_pkg::*;
(
  // clock and reset
  input wire logic       MCLK,
  input wire logic       RST,
  // register bus
  input wire logic [3:0] addr,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic       capture_irq,
  input wire logic       overflow_irq,
  input wire logic       capture_ack,
  input wire logic       overflow_ack
);
  // ----------------------------------------
  // shadows of what the bus has written
  // ----------------------------------------
  logic [7:0]  mask_sh;
  logic [7:0]  tmp_sh;
  logic [15:0] cnt_sh;
  logic        tmp_ok;
  logic        cnt_ok;
  logic        stopped;
  logic        hi_wr;
  assign hi_wr = wr && addr[0] && addr >= ADDR_CNT_HI && addr <= ADDR_CMPA_HI;

  // the counter value is only predictable while no clock is selected
  always_ff @(posedge MCLK or posedge RST)
    if (RST)
    begin
      mask_sh <= 8'h00;
      stopped <= 1'h1;
      cnt_sh  <= 16'h0000;
      cnt_ok  <= 1'h1;
    end
    else
    begin
      if (wr && addr == ADDR_MASK)
        mask_sh <= wdata;
      if (wr && addr == ADDR_CTRL_B)
        stopped <= (wdata[2:0] == 3'h0);
      if (wr && addr == ADDR_CNT_LO)
        cnt_sh <= {tmp_sh, wdata};
      cnt_ok <= stopped && (wr && addr == ADDR_CNT_LO ? tmp_ok : cnt_ok);
    end

  // shared holding byte; a capture low read makes it unknown here
  always_ff @(posedge MCLK or posedge RST)
    if (RST)
    begin
      tmp_sh <= 8'h00;
      tmp_ok <= 1'h1;
    end
    else if (hi_wr)
    begin
      tmp_sh <= wdata;
      tmp_ok <= 1'h1;
    end
    else if (rd && addr == ADDR_CNT_LO)
    begin
      tmp_sh <= cnt_sh[15:8];
      tmp_ok <= cnt_ok;
    end
    else if (rd && addr == ADDR_CAP_LO)
      tmp_ok <= 1'h0;

  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RST);

  sequence s_lo_read;
    cnt_ok && rd && addr == ADDR_CNT_LO;
  endsequence
  sequence s_hi_read;
    rd && addr == ADDR_CNT_HI;
  endsequence

  a_cap_irq_mask: assert property (capture_irq |-> mask_sh[POS_CAP_FLAG])
    else $error("capture request while disabled");
  a_ovf_irq_mask: assert property (overflow_irq |-> mask_sh[POS_OVF_FLAG])
    else $error("overflow request while disabled");
  a_rdata_hold: assert property (!rd |=> $stable(rdata))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (rd && addr > ADDR_CMP_CTRL |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_stopped_low: assert property (s_lo_read |=> rdata == cnt_sh[7:0])
    else $error("stopped counter low byte wrong");
  a_commit_high: assert property (s_lo_read ##1 s_hi_read |=> rdata == cnt_sh[15:8])
    else $error("counter high byte not committed");
  a_holding_read: assert property (tmp_ok && rd && (addr == ADDR_CNT_HI || addr == ADDR_CAP_HI) |=> rdata == $past(tmp_sh))
    else $error("high read did not return holding byte");
  a_cap_flag_hold: assert property (capture_irq && !capture_ack && !wr |=> capture_irq)
    else $error("capture flag dropped without clear");
  a_ovf_flag_hold: assert property (overflow_irq && !overflow_ack && !wr |=> overflow_irq)
    else $error("overflow flag dropped without clear");
endmodule : timer16_props

// [timer16_counter_input_capture_tb_top.sv]
// timer16 bench: host end and device end joined, driven from user ports
// assumes: MCLK of 100 ns; stimulus changes on falling edges
`timescale 1ns/1ns
module timer16_counter_input_capture_tb_top
  import timer16_pkg::*;
;
  logic        MCLK = 0, RST = 1, REQ = 0, CAP_PIN = 0, CMP_OUT = 0;
  logic        CAP_SVC = 0, OVF_SVC = 0;
  host_op_t    OP = OP_READ8;
  logic [3:0]  ADDR = 4'h0;
  logic [15:0] WDATA = 16'h0000, RDATA, v;
  logic        BUSY, DONE, CEILING, FLOOR, CAP_IRQ, OVF_IRQ;
  logic [31:0] seed = 32'd11;
  int          err_count = 0, compares = 0, cyc = 0, n, lat0, lat1;
  logic [15:0] vals[4];
  logic [3:0]  modes[6] = '{4'h1, 4'h5, 4'h4, 4'h6, 4'h7, 4'h5};
  // last pass runs on the divide-by-8 tick: 255 ticks of 8 cycles
  logic [2:0]  sels[6] = '{3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h2};
  logic [15:0] ups[6] = '{CEIL_8BIT, CEIL_8BIT, 16'h0140, CEIL_9BIT,
                          CEIL_10BIT, 16'h07F8};
  logic [15:0] downs[6] = '{CEIL_8BIT, 16'h0001, 16'h0001, 16'h0001,
                            16'h0001, 16'h0008};

  timer16_bus_if bus ();
  timer16_device timer16_device_i (.MCLK(MCLK), .RST(RST), .BUS(bus.device),
    .CAPTURE_PIN(CAP_PIN), .COMPARATOR_OUT(CMP_OUT), .CEILING(CEILING),
    .FLOOR(FLOOR));
  timer16_host timer16_host_i (.MCLK(MCLK), .RST(RST), .BUS(bus.host),
    .REQ(REQ), .OP(OP), .ADDR(ADDR), .WDATA(WDATA), .BUSY(BUSY),
    .DONE(DONE), .RDATA(RDATA), .CAPTURE_IRQ(CAP_IRQ),
    .OVERFLOW_IRQ(OVF_IRQ), .CAPTURE_SERVICE(CAP_SVC),
    .OVERFLOW_SERVICE(OVF_SVC));
  timer16_props timer16_props_i (.MCLK(MCLK), .RST(RST), .addr(bus.addr),
    .wr(bus.wr), .rd(bus.rd), .wdata(bus.wdata), .rdata(bus.rdata),
    .capture_irq(bus.capture_irq), .overflow_irq(bus.overflow_irq),
    .capture_ack(bus.capture_ack), .overflow_ack(bus.overflow_ack));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  initial
    forever #50 MCLK = ~MCLK;

  function automatic logic [15:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction : rnd

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  // one host request; returns one cycle after done so rdata is whole
  task automatic op(input host_op_t o, input logic [3:0] a,
                    input logic [15:0] d);
    int k;
    k = 0;
    @(negedge MCLK);
    REQ = 1;
    OP = o;
    ADDR = a;
    WDATA = d;
    @(negedge MCLK);
    chk("busy", 16'h0001, {15'h0000, BUSY});
    REQ = 0;
    while (DONE !== 1'b1 && k < 20)
    begin
      @(negedge MCLK);
      k++;
    end
    chk("request done", (o inside {OP_WRITE16, OP_READ16}) ?
        16'h0002 : 16'h0001, k[15:0]);
    @(negedge MCLK);
  endtask : op

  // cycles floor to ceiling, then ceiling back to floor
  task automatic span(input logic [15:0] up, input logic [15:0] dn);
    int k;
    k = 0;
    while (FLOOR !== 1'b1 && k < 3000)
    begin
      @(negedge MCLK);
      k++;
    end
    k = 0;
    while (CEILING !== 1'b1 && k < 3000)
    begin
      @(negedge MCLK);
      k++;
    end
    chk("floor to ceiling", up, k[15:0]);
    k = 0;
    while (FLOOR !== 1'b1 && k < 3000)
    begin
      @(negedge MCLK);
      k++;
    end
    chk("ceiling to floor", dn, k[15:0]);
  endtask : span

  // toggle a capture source, count cycles until the capture request
  task automatic fire(input logic cmp, output int k);
    @(negedge MCLK);
    if (cmp)
      CMP_OUT = ~CMP_OUT;
    else
      CAP_PIN = ~CAP_PIN;
    k = 0;
    while (CAP_IRQ !== 1'b1 && k < 20)
    begin
      @(negedge MCLK);
      k++;
    end
  endtask : fire

  always @(posedge MCLK)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      err_count++;
      wrap_up();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (8) @(posedge MCLK);
    @(negedge MCLK);
    RST = 0;
    // stopped counter: corners and random values written then read back
    vals = '{16'h0000, 16'hFFFF, rnd(), rnd()};
    op(OP_READ16, ADDR_CNT_LO, 16'h0000);
    chk("counter reset", RESET_WORD, RDATA);
    foreach (vals[i])
    begin
      op(OP_WRITE16, ADDR_CNT_LO, vals[i]);
      op(OP_READ16, ADDR_CNT_LO, 16'h0000);
      chk("counter", vals[i], RDATA);
    end
    op(OP_READ8, 4'hF, 16'h0000);
    chk("unmapped", 16'h0000, {8'h00, RDATA[7:0]});
    // running counter: ceilings per mode, overflow kept masked
    op(OP_WRITE8, ADDR_MASK, 16'h0000);
    op(OP_WRITE16, ADDR_CMPA_LO, 16'h0140);
    op(OP_WRITE16, ADDR_CNT_LO, 16'h0000);
    foreach (modes[i])
    begin
      op(OP_WRITE8, ADDR_CTRL_A, {14'h0000, modes[i][1:0]});
      op(OP_WRITE8, ADDR_CTRL_B, {11'h000, modes[i][3:2], sels[i]});
      span(ups[i], downs[i]);
    end
    chk("masked overflow", 16'h0000, {15'h0000, OVF_IRQ});
    op(OP_WRITE8, ADDR_CTRL_B, 16'h0040);
    op(OP_WRITE8, ADDR_CTRL_A, 16'h0000);
    op(OP_WRITE8, ADDR_MASK, 16'h0024);
    chk("overflow request", 16'h0001, {15'h0000, OVF_IRQ});
    OVF_SVC = 1;
    @(negedge MCLK);
    OVF_SVC = 0;
    chk("overflow serviced", 16'h0000, {15'h0000, OVF_IRQ});
    // pin capture on rising edge, then falling edge ignored
    v = rnd();
    op(OP_WRITE16, ADDR_CNT_LO, v);
    fire(1'b0, lat0);
    chk("pin capture", 16'h0001, {15'h0000, lat0 < 20});
    op(OP_READ16, ADDR_CAP_LO, 16'h0000);
    chk("capture value", v, RDATA);
    op(OP_WRITE8, ADDR_FLAGS, 16'h0020);
    chk("flag write clear", 16'h0000, {15'h0000, CAP_IRQ});
    fire(1'b0, n);
    chk("falling ignored", 16'h0014, n[15:0]);
    // filter adds four cycles and swallows a short pulse
    op(OP_WRITE8, ADDR_CTRL_B, 16'h00C0);
    fire(1'b0, lat1);
    chk("filter delay", lat0[15:0] + 16'h0004, lat1[15:0]);
    CAP_SVC = 1;
    @(negedge MCLK);
    CAP_SVC = 0;
    chk("flag serviced", 16'h0000, {15'h0000, CAP_IRQ});
    CAP_PIN = 0;
    repeat (10) @(negedge MCLK);
    CAP_PIN = 1;
    repeat (3) @(negedge MCLK);
    CAP_PIN = 0;
    repeat (15) @(negedge MCLK);
    chk("glitch filtered", 16'h0000, {15'h0000, CAP_IRQ});
    // comparator source, new capture overwrites the old one
    op(OP_WRITE8, ADDR_CMP_CTRL, 16'h0004);
    op(OP_WRITE8, ADDR_FLAGS, 16'h0020);
    op(OP_WRITE8, ADDR_CTRL_B, 16'h0040);
    v = rnd();
    op(OP_WRITE16, ADDR_CNT_LO, v);
    fire(1'b1, n);
    chk("comparator latency", 16'h0003, n[15:0]);
    op(OP_READ16, ADDR_CAP_LO, 16'h0000);
    chk("comparator capture", v, RDATA);
    // capture writes refused in mode 0, taken in mode 12
    op(OP_WRITE16, ADDR_CAP_LO, 16'h1234);
    op(OP_READ16, ADDR_CAP_LO, 16'h0000);
    chk("refused write", v, RDATA);
    // falling edge selected, but mode 12 idles the edge detector, so the next comparator change is not captured
    op(OP_WRITE8, ADDR_CTRL_B, 16'h0018);
    v = rnd();
    op(OP_WRITE16, ADDR_CAP_LO, v);
    op(OP_READ16, ADDR_CAP_LO, 16'h0000);
    chk("ceiling write", v, RDATA);
    op(OP_WRITE8, ADDR_FLAGS, 16'h0020);
    fire(1'b1, n);
    chk("input off", 16'h0014, n[15:0]);
    wrap_up();
  end
endmodule : timer16_counter_input_capture_tb_top
